// [board_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board side of the pads: resolves every wire
// ------------------------------------------------------------
module board_model (
    // Device drive
    input wire logic [7:0] first_pad_out,
    input wire logic [7:0] first_pad_oe,
    input wire logic [4:0] second_pad_out,
    input wire logic [4:0] second_pad_oe,
    // Board drive where the device lets go
    input wire logic [7:0] first_ext,
    input wire logic [5:0] second_ext,
    // Levels seen by the device
    output logic [7:0] first_pad_in,
    output logic [5:0] second_pad_in
);
    // a driving device wins over the board
    assign first_pad_in = (first_pad_oe & first_pad_out) |
        (~first_pad_oe & first_ext);
    // the top pin is only ever driven by the board
    assign second_pad_in = {second_ext[5], (second_pad_oe & second_pad_out)
        | (~second_pad_oe & second_ext[4:0])};
endmodule : board_model

// [gpio_fg_checker.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pad checks against a shadow of the written registers
// ------------------------------------------------------------
module gpio_fg_checker (
    // Clock, reset and bus
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Pads
    input wire logic [7:0] first_pad_in,
    input wire logic [7:0] first_pad_out,
    input wire logic [7:0] first_pad_oe,
    input wire logic [5:0] second_pad_in,
    input wire logic [4:0] second_pad_out,
    input wire logic [4:0] second_pad_oe,
    // Peripheral side
    input wire logic master_clear_enable_bit,
    input wire logic master_clear_input,
    input wire logic can_transmit_pin,
    input wire logic can_complement_transmit_pin,
    input wire logic can_complement_oe,
    input wire logic can_receive_pin,
    input wire logic pwm_output_four,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic comparator_reference_output,
    input wire logic [2:0] comparator_mode,
    input wire logic slave_select_n
);
    // Shadows move on the completing edge, as the design does
    logic [7:0] fdir_reg, flat_reg, fmask;
    logic [4:0] sdir_reg, slat_reg, smask;
    logic [5:0] pen_reg;
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    // Pins not taken over by an enabled peripheral
    assign fmask = ~{pen_reg[5], 1'b0, pen_reg[4], 2'b00, pen_reg[2],
        pen_reg[3], 1'b0};
    assign smask = {~pen_reg[1], 1'b1, {3{~pen_reg[0]}}};
    // Pins register writes reach the latch too
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fdir_reg <= 8'hff;
            flat_reg <= 8'h00;
            sdir_reg <= 5'h1f;
            slat_reg <= 5'h00;
            pen_reg <= 6'h00;
        end else if (wr) begin
            case (paddr)
                8'h00: fdir_reg <= pwdata[7:0];
                8'h04, 8'h08: flat_reg <= pwdata[7:0];
                8'h0c: sdir_reg <= pwdata[4:0];
                8'h10, 8'h14: slat_reg <= pwdata[4:0];
                8'h20: pen_reg <= pwdata[5:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    first_io_a: assert property (
        ((first_pad_oe ^ ~fdir_reg) & fmask) == 8'h00 &&
        ((first_pad_out ^ flat_reg) & first_pad_oe & fmask) == 8'h00)
        else $error("first port pad drive wrong");
    second_io_a: assert property (
        ((second_pad_oe ^ ~sdir_reg) & smask) == 5'h00 &&
        ((second_pad_out ^ slat_reg) & second_pad_oe & smask) == 5'h00)
        else $error("second port pad drive wrong");
    reset_input_a: assert property ($rose(arst_n) |->
        first_pad_oe == 8'h00 && second_pad_oe == 5'h00)
        else $error("pads driven after reset");
    master_clear_a: assert property (master_clear_input ==
        (master_clear_enable_bit ? second_pad_in[5] : 1'b1))
        else $error("master clear routing wrong");
    can_map_a: assert property (
        can_receive_pin == (pen_reg[0] ? second_pad_in[2] : 1'b1) &&
        (!pen_reg[0] || (second_pad_oe[0] && !second_pad_oe[2] &&
        second_pad_out[0] == can_transmit_pin &&
        second_pad_oe[1] == can_complement_oe &&
        second_pad_out[1] == can_complement_transmit_pin)))
        else $error("can pin mapping wrong");
    pwm_map_a: assert property (pen_reg[1] |-> second_pad_oe[4] &&
        second_pad_out[4] == pwm_output_four)
        else $error("pwm pin mapping wrong");
    cmp_out_a: assert property (
        (!pen_reg[2] || (first_pad_oe[2] &&
        first_pad_out[2] == comparator_one_output)) &&
        (!pen_reg[3] || (first_pad_oe[1] &&
        first_pad_out[1] == comparator_two_output)))
        else $error("comparator output mapping wrong");
    ref_out_a: assert property (pen_reg[4] |-> first_pad_oe[5] &&
        first_pad_out[5] == comparator_reference_output)
        else $error("reference output mapping wrong");
    slave_sel_a: assert property (
        slave_select_n == (pen_reg[5] ? first_pad_in[7] : 1'b1) &&
        (!pen_reg[5] || !first_pad_oe[7]))
        else $error("slave select mapping wrong");
    mode_write_a: assert property (wr && paddr == 8'h1c |=>
        comparator_mode == $past(pwdata[2:0]))
        else $error("comparator mode not written");
    cover property (wr && paddr == 8'h20 && pwdata[5:0] == 6'h3f);
    cover property (wr && paddr == 8'h1c && pwdata[2:0] == 3'h7);
    cover property (master_clear_enable_bit && !master_clear_input);
endmodule : gpio_fg_checker

bind gpio_ports_fg gpio_fg_checker gpio_fg_checker_i (.*);

// [gpio_fg_pkg.sv]
// Contract
// - Second-port direction one tristates the pin
// - Second-port direction zero drives latch bit
// - Second port: six pins, five bidirectional
// - Second-port latch read returns latch value
// - Peripheral forced direction never stored
// - Second-port pins are inputs after reset
// - Input-only bit digital when clear disabled
// - Input-only bit is master clear, never drives
// - Second-port bits zero-two shared with CAN
// - Second-port bit four selectable PWM output
// - First-port bits one, two comparator outputs
// - First-port bit five comparator reference out
// - First-port bit seven serial slave select
// - Comparators off, analog config makes digital
// - First-port direction one tristates, zero drives
// - First-port latch read returns latch value
// - First-port pins six-zero read zero analog
package gpio_fg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] first_dir_off = 8'h00;
    localparam logic [7:0] first_pins_off = 8'h04;
    localparam logic [7:0] first_latch_off = 8'h08;
    localparam logic [7:0] second_dir_off = 8'h0c;
    localparam logic [7:0] second_pins_off = 8'h10;
    localparam logic [7:0] second_latch_off = 8'h14;
    localparam logic [7:0] analog_cfg_off = 8'h18;
    localparam logic [7:0] comp_ctrl_off = 8'h1c;
    localparam logic [7:0] periph_en_off = 8'h20;
    localparam logic [7:0] config_off = 8'h24;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int first_w = 8;
    localparam int second_w = 6;
    localparam int second_io_w = 5;
    localparam logic [7:0] first_dir_rst = 8'hff;
    localparam logic [7:0] first_latch_rst = 8'h00;
    localparam logic [4:0] second_dir_rst = 5'h1f;
    localparam logic [4:0] second_latch_rst = 5'h00;
    localparam logic [3:0] analog_cfg_rst = 4'h0;
    localparam logic [2:0] comp_ctrl_rst = 3'h0;
    // Values that make every first-port pin digital
    localparam logic [3:0] analog_all_digital = 4'hf;
    localparam logic [2:0] comp_all_off = 3'h7;

    // ------------------------------------------------------------
    // Field positions in the peripheral enable register
    // ------------------------------------------------------------
    localparam int pen_can = 0;
    localparam int pen_pwm4 = 1;
    localparam int pen_cmp1_out = 2;
    localparam int pen_cmp2_out = 3;
    localparam int pen_ref_out = 4;
    localparam int pen_ssel = 5;
    localparam int pen_w = 6;

endpackage : gpio_fg_pkg

// [gpio_pin_cell.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One pin: direction, latch and peripheral override
// ----------------------------------------------------------------
module gpio_pin_cell (
    // Stored port state
    input wire logic dir_bit,
    input wire logic latch_bit,
    // Peripheral override
    input wire logic periph_en,
    input wire logic periph_oe,
    input wire logic periph_out,
    // Pad side
    output logic pad_out,
    output logic pad_oe
);

    // Override acts on the pad only; the stored bit is untouched
    always_comb begin
        if (periph_en) begin
            pad_oe = periph_oe;
            pad_out = periph_out;
        end else begin
            pad_oe = ~dir_bit;
            pad_out = latch_bit;
        end
    end

endmodule : gpio_pin_cell

// [gpio_ports_fg.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two general purpose ports behind an APB slave
// ----------------------------------------------------------------
module gpio_ports_fg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // First port pads
    input wire logic [7:0] first_pad_in,
    output logic [7:0] first_pad_out,
    output logic [7:0] first_pad_oe,
    // Second port pads, bit five input only
    input wire logic [5:0] second_pad_in,
    output logic [4:0] second_pad_out,
    output logic [4:0] second_pad_oe,
    // Master clear strap and resulting reset request
    input wire logic master_clear_enable_bit,
    output logic master_clear_input,
    // CAN peripheral
    input wire logic can_transmit_pin,
    input wire logic can_complement_transmit_pin,
    input wire logic can_complement_oe,
    output logic can_receive_pin,
    // PWM peripheral
    input wire logic pwm_output_four,
    // Comparator block
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic comparator_reference_output,
    output logic [2:0] comparator_mode,
    output logic [3:0] analog_pin_mode,
    // Serial port slave select
    output logic slave_select_n
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] first_port_direction_reg; // Stored direction, 1 = input
    logic [7:0] first_port_latch_reg; // Output latch
    logic [4:0] second_port_direction_reg; // Five drivable pins only
    logic [4:0] second_port_latch_reg; // Output latch
    logic [3:0] analog_pin_configuration_reg; // Analog selection
    logic [2:0] comparator_control_reg; // Comparator mode
    logic [5:0] periph_en_reg; // Peripheral selects per function
    logic [31:0] prdata_next; // Read mux result
    logic wr_en; // Write taken this edge
    logic [7:0] first_analog; // First-port pins in analog mode
    logic [7:0] first_pen; // Per-pin peripheral enable
    logic [7:0] first_poe; // Per-pin peripheral output enable
    logic [7:0] first_pout; // Per-pin peripheral data
    logic [7:0] first_pins_view; // What software reads as pin level
    // Second port override set; bit five has no driver at all
    logic [4:0] second_pen;
    logic [4:0] second_poe;
    logic [4:0] second_pout;
    logic [5:0] second_pins_view;
    logic digital_mode; // Comparators off and pins digital

    // Zero-wait slave: every access finishes in its first access cycle
    assign pready = 1'b1;
    // Writes land at the access edge; unmapped offsets hit nothing
    assign wr_en = psel & penable & pwrite;

    // Decode a byte offset against one register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // Unmapped offsets answer with an error
    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, gpio_fg_pkg::first_dir_off) |
                 hit(a, gpio_fg_pkg::first_pins_off) |
                 hit(a, gpio_fg_pkg::first_latch_off) |
                 hit(a, gpio_fg_pkg::second_dir_off) |
                 hit(a, gpio_fg_pkg::second_pins_off) |
                 hit(a, gpio_fg_pkg::second_latch_off) |
                 hit(a, gpio_fg_pkg::analog_cfg_off) |
                 hit(a, gpio_fg_pkg::comp_ctrl_off) |
                 hit(a, gpio_fg_pkg::periph_en_off) |
                 hit(a, gpio_fg_pkg::config_off);
    endfunction : mapped

    assign pslverr = psel & penable & ~mapped(paddr);

    // ------------------------------------------------------------
    // First port registers
    // ------------------------------------------------------------
    // Direction register; overrides never land here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_port_direction_reg <= gpio_fg_pkg::first_dir_rst;
        end else if (wr_en && hit(paddr, gpio_fg_pkg::first_dir_off)) begin
            first_port_direction_reg <= pwdata[7:0];
        end
    end

    // Latch written through either the pins or the latch offset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_port_latch_reg <= gpio_fg_pkg::first_latch_rst;
        end else if (wr_en && (hit(paddr, gpio_fg_pkg::first_pins_off) ||
                 hit(paddr, gpio_fg_pkg::first_latch_off))) begin
            first_port_latch_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Second port registers
    // ------------------------------------------------------------
    // inputs after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            second_port_direction_reg <= gpio_fg_pkg::second_dir_rst;
        end else if (wr_en && hit(paddr, gpio_fg_pkg::second_dir_off)) begin
            second_port_direction_reg <= pwdata[4:0];
        end
    end

    // Latch reset is undefined in hardware; zero keeps sims clean
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            second_port_latch_reg <= gpio_fg_pkg::second_latch_rst;
        end else if (wr_en && (hit(paddr, gpio_fg_pkg::second_pins_off) ||
                 hit(paddr, gpio_fg_pkg::second_latch_off))) begin
            second_port_latch_reg <= pwdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    // Analog and comparator setup, plus peripheral selects
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_pin_configuration_reg <= gpio_fg_pkg::analog_cfg_rst;
            comparator_control_reg <= gpio_fg_pkg::comp_ctrl_rst;
            periph_en_reg <= '0;
        end else if (wr_en) begin
            // Each mode register decodes its own offset
            if (hit(paddr, gpio_fg_pkg::analog_cfg_off)) begin
                analog_pin_configuration_reg <= pwdata[3:0];
            end
            if (hit(paddr, gpio_fg_pkg::comp_ctrl_off)) begin
                comparator_control_reg <= pwdata[2:0];
            end
            if (hit(paddr, gpio_fg_pkg::periph_en_off)) begin
                periph_en_reg <= pwdata[gpio_fg_pkg::pen_w-1:0];
            end
        end
    end

    // Analog and comparator mode registers go straight out to the analog blocks
    assign comparator_mode = comparator_control_reg;
    assign analog_pin_mode = analog_pin_configuration_reg;

    assign digital_mode =
        (comparator_control_reg == gpio_fg_pkg::comp_all_off) &&
        (analog_pin_configuration_reg == gpio_fg_pkg::analog_all_digital);
    assign first_analog = digital_mode ? 8'h00 : 8'h7f;

    // ------------------------------------------------------------
    // First port peripheral overrides
    // ------------------------------------------------------------
    // Pins without a peripheral stay with direction and latch
    always_comb begin
        first_pen = 8'h00;
        first_poe = 8'h00;
        first_pout = 8'h00;
        first_pen[1] = periph_en_reg[gpio_fg_pkg::pen_cmp2_out];
        first_poe[1] = 1'b1;
        first_pout[1] = comparator_two_output;
        first_pen[2] = periph_en_reg[gpio_fg_pkg::pen_cmp1_out];
        first_poe[2] = 1'b1;
        first_pout[2] = comparator_one_output;
        first_pen[5] = periph_en_reg[gpio_fg_pkg::pen_ref_out];
        first_poe[5] = 1'b1;
        first_pout[5] = comparator_reference_output;
        first_pen[7] = periph_en_reg[gpio_fg_pkg::pen_ssel];
        first_poe[7] = 1'b0;
    end

    // Slave select idles high when the function is off
    assign slave_select_n = periph_en_reg[gpio_fg_pkg::pen_ssel] ?
                            first_pad_in[7] : 1'b1;

    // ------------------------------------------------------------
    // Second port peripheral overrides
    // ------------------------------------------------------------
    // CAN owns bits zero to two together; bit three has no peripheral
    always_comb begin
        second_pen = 5'h00;
        second_poe = 5'h00;
        second_pout = 5'h00;
        second_pen[0] = periph_en_reg[gpio_fg_pkg::pen_can];
        second_poe[0] = 1'b1;
        second_pout[0] = can_transmit_pin;
        second_pen[1] = periph_en_reg[gpio_fg_pkg::pen_can];
        second_poe[1] = can_complement_oe;
        second_pout[1] = can_complement_transmit_pin;
        second_pen[2] = periph_en_reg[gpio_fg_pkg::pen_can];
        second_poe[2] = 1'b0;
        second_pen[4] = periph_en_reg[gpio_fg_pkg::pen_pwm4];
        second_poe[4] = 1'b1;
        second_pout[4] = pwm_output_four;
    end

    // Receive idles recessive (high) when CAN does not own the pin
    assign can_receive_pin = periph_en_reg[gpio_fg_pkg::pen_can] ?
                             second_pad_in[2] : 1'b1;

    // ------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------
    // One cell per drivable pin; the input-only pin has none
    genvar i;
    generate
        for (i = 0; i < gpio_fg_pkg::first_w; i++) begin : g_first
            gpio_pin_cell u_cell (
                .dir_bit(first_port_direction_reg[i]),
                .latch_bit(first_port_latch_reg[i]),
                .periph_en(first_pen[i]),
                .periph_oe(first_poe[i]),
                .periph_out(first_pout[i]),
                .pad_out(first_pad_out[i]),
                .pad_oe(first_pad_oe[i])
            );
        end
        for (i = 0; i < gpio_fg_pkg::second_io_w; i++) begin : g_second
            gpio_pin_cell u_cell (
                .dir_bit(second_port_direction_reg[i]),
                .latch_bit(second_port_latch_reg[i]),
                .periph_en(second_pen[i]),
                .periph_oe(second_poe[i]),
                .periph_out(second_pout[i]),
                .pad_out(second_pad_out[i]),
                .pad_oe(second_pad_oe[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin views and master clear
    // ------------------------------------------------------------
    // analog pins read zero
    assign first_pins_view = first_pad_in & ~first_analog;
    assign master_clear_input = master_clear_enable_bit ?
                                second_pad_in[5] : 1'b1;
    assign second_pins_view = {
        second_pad_in[5] & ~master_clear_enable_bit,
        second_pad_in[4:0]
    };

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        prdata_next = 32'h0000_0000;
        case (paddr)
            // Stored direction; overrides are not shown here
            gpio_fg_pkg::first_dir_off: begin
                prdata_next[7:0] = first_port_direction_reg;
            end
            gpio_fg_pkg::first_pins_off: begin
                prdata_next[7:0] = first_pins_view;
            end
            gpio_fg_pkg::first_latch_off: begin
                prdata_next[7:0] = first_port_latch_reg;
            end
            // Only the five drivable pins have a direction bit
            gpio_fg_pkg::second_dir_off: begin
                prdata_next[4:0] = second_port_direction_reg;
            end
            // Pin levels, input-only bit included
            gpio_fg_pkg::second_pins_off: begin
                prdata_next[5:0] = second_pins_view;
            end
            gpio_fg_pkg::second_latch_off: begin
                prdata_next[4:0] = second_port_latch_reg;
            end
            // Analog selection readback
            gpio_fg_pkg::analog_cfg_off: begin
                prdata_next[3:0] = analog_pin_configuration_reg;
            end
            // Comparator mode readback
            gpio_fg_pkg::comp_ctrl_off: begin
                prdata_next[2:0] = comparator_control_reg;
            end
            // Peripheral selects readback
            gpio_fg_pkg::periph_en_off: begin
                prdata_next[5:0] = periph_en_reg;
            end
            // Status: strap level and digital mode, read only
            gpio_fg_pkg::config_off: begin
                prdata_next[0] = master_clear_enable_bit;
                prdata_next[1] = digital_mode;
            end
            // Unmapped offsets read zero
            default: begin
                prdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered in the setup cycle, valid in access cycle
    // A pin change during the access cycle shows on the next read only
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
        end
    end

endmodule : gpio_ports_fg

// [tb_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register and pad tests over APB
// ------------------------------------------------------------
module tb_top;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, first_pad_in, first_pad_out, first_pad_oe, first_ext;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] second_pad_in, second_ext;
    logic [4:0] second_pad_out, second_pad_oe;
    logic master_clear_enable_bit, master_clear_input, can_receive_pin;
    logic can_transmit_pin, can_complement_transmit_pin, can_complement_oe;
    logic pwm_output_four, comparator_one_output, comparator_two_output;
    logic comparator_reference_output, slave_select_n, err_seen;
    logic [2:0] comparator_mode;
    logic [3:0] analog_pin_mode;
    logic [31:0] rst_exp [10] = '{32'hff, 32'h80, 32'h0, 32'h1f, 32'h3f,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int err_total = 0;
    int total_checks = 0;

    gpio_ports_fg gpio_ports_fg_i (.*);
    board_model board_model_i (.*);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {first_ext, second_ext} = '1;
        {master_clear_enable_bit, can_complement_transmit_pin} = 2'b00;
        {can_complement_oe, comparator_two_output} = 2'b00;
        {can_transmit_pin, pwm_output_four} = 2'b11;
        {comparator_one_output, comparator_reference_output} = 2'b11;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, analog pins read zero
        for (int i = 0; i < 10; i++) rdc(8'(i * 4), rst_exp[i]);
        // Unmapped place is refused and reads zero
        apb(1'b1, 8'h28, 32'hffffffff);
        chk(32'(err_seen), 32'h1);
        rdc(8'h28, 32'h0);
        // Comparators off and all pins digital
        apb(1'b1, 8'h1c, 32'h07);
        apb(1'b1, 8'h18, 32'h0f);
        rdc(8'h04, 32'hff);
        rdc(8'h24, 32'h02);
        chk(32'({comparator_mode, analog_pin_mode}), 32'h7f);
        // First port: pins write the latch, pins read the wire
        first_ext <= 8'h00;
        apb(1'b1, 8'h00, 32'hcf);
        apb(1'b1, 8'h04, 32'h20);
        rdc(8'h08, 32'h20);
        rdc(8'h04, 32'h20);
        apb(1'b1, 8'h08, 32'h5a);
        rdc(8'h04, 32'h10);
        @(negedge core_clk);
        chk(32'(first_pad_oe), 32'h30);
        // Second port: five drivers, latch read back
        second_ext <= 6'h00;
        apb(1'b1, 8'h0c, 32'h04);
        apb(1'b1, 8'h14, 32'h3f);
        rdc(8'h14, 32'h1f);
        rdc(8'h10, 32'h1b);
        @(negedge core_clk);
        chk(32'({second_pad_oe, second_pad_out}), 32'h37f);
        apb(1'b1, 8'h10, 32'h01);
        rdc(8'h14, 32'h01);
        // Every peripheral on: pins taken over, directions kept
        can_transmit_pin <= 1'b0;
        {can_complement_oe, can_complement_transmit_pin} <= 2'b11;
        apb(1'b1, 8'h20, 32'h3f);
        rdc(8'h00, 32'hcf);
        rdc(8'h0c, 32'h04);
        @(negedge core_clk);
        chk(32'({can_receive_pin, slave_select_n}), 32'h0);
        chk(32'({second_pad_oe[4], second_pad_out[4], second_pad_oe[1],
            second_pad_out[1], second_pad_oe[0], second_pad_out[0]}),
            32'h3e);
        chk(32'({first_pad_oe[5], first_pad_oe[2:1], first_pad_out[5],
            first_pad_out[2:1]}), 32'h3e);
        apb(1'b1, 8'h20, 32'h00);
        // Master clear strap on the input-only pin
        master_clear_enable_bit <= 1'b1;
        rdc(8'h24, 32'h03);
        chk(32'(master_clear_input), 32'h0);
        master_clear_enable_bit <= 1'b0;
        @(negedge core_clk);
        chk(32'(master_clear_input), 32'h1);
        // Second reset in mid-run
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        chk(32'({first_pad_oe, second_pad_oe}), 32'h0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        rdc(8'h0c, 32'h1f);
        end_of_test();
    end
endmodule : tb_top
